// file: design/dep_pkg.sv
// package for the decimal edit pattern engine: constants, opcodes, states and bus carriers
package dep_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] DEP_CTRL = 8'h00;
  localparam logic [7:0] DEP_STAT = 8'h04;
  localparam logic [7:0] DEP_SRCLEN = 8'h08;
  localparam logic [7:0] DEP_SRCPTR = 8'h0c;
  localparam logic [7:0] DEP_SIGNFILL = 8'h10;
  localparam logic [7:0] DEP_PATPTR = 8'h14;
  localparam logic [7:0] DEP_DSTPTR = 8'h18;
  // control and status bit positions
  localparam int DEP_CTRL_GO = 0;
  localparam int DEP_CTRL_NEG = 1;
  localparam int DEP_ST_BUSY = 0;
  localparam int DEP_ST_DONE = 1;
  localparam int DEP_ST_ABORT = 2;
  localparam int DEP_ST_BADOP = 3;
  localparam int DEP_ST_N = 4;
  localparam int DEP_ST_Z = 5;
  localparam int DEP_ST_V = 6;
  localparam int DEP_ST_C = 7;
  // reset values, ascii zero and adjust limit
  localparam logic [7:0] DEP_FILL_RST = 8'h20;
  localparam logic [7:0] DEP_SIGN_RST = 8'h20;
  localparam logic [7:0] DEP_ASCII_ZERO = 8'h30;
  localparam logic [5:0] DEP_ADJ_MAX = 6'h1f;
  // pattern opcodes
  localparam logic [7:0] DEP_OP_END = 8'h00;
  localparam logic [7:0] DEP_OP_ENDFLT = 8'h01;
  localparam logic [7:0] DEP_OP_CLRSIG = 8'h02;
  localparam logic [7:0] DEP_OP_SETSIG = 8'h03;
  localparam logic [7:0] DEP_OP_STSIGN = 8'h04;
  localparam logic [7:0] DEP_OP_LDFILL = 8'h40;
  localparam logic [7:0] DEP_OP_LDSIGN = 8'h41;
  localparam logic [7:0] DEP_OP_LDPLUS = 8'h42;
  localparam logic [7:0] DEP_OP_LDMINUS = 8'h43;
  localparam logic [7:0] DEP_OP_INSERT = 8'h44;
  localparam logic [7:0] DEP_OP_BLANK = 8'h45;
  localparam logic [7:0] DEP_OP_REPSIGN = 8'h46;
  localparam logic [7:0] DEP_OP_ADJUST = 8'h47;
  localparam logic [3:0] DEP_GRP_FILL = 4'h8;
  localparam logic [3:0] DEP_GRP_MOVE = 4'h9;
  localparam logic [3:0] DEP_GRP_FLOAT = 4'ha;
  // engine states, one-hot
  typedef enum logic [7:0] {
    DEP_IDLE = 8'h01,
    DEP_FETCH = 8'h02,
    DEP_DECODE = 8'h04,
    DEP_OPND = 8'h08,
    DEP_DIGIT = 8'h10,
    DEP_STORE = 8'h20,
    DEP_DROP = 8'h40,
    DEP_FINISH = 8'h80
  } dep_state_t;
  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dep_apb_req_t;
  // memory request carrier
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } dep_mem_req_t;
endpackage

// file: design/dep_engine.sv
// decimal edit pattern engine: apb slave plus byte-memory pattern interpreter
`timescale 1ns/1ps
module dep_engine (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire dep_pkg::dep_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // byte memory port
  output dep_pkg::dep_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // completion
  output logic done
);
  import dep_pkg::*;

  dep_state_t state_r;
  logic [31:0] srclen_r; // upper half: negative count of zeros to supply
  logic [31:0] srcptr_r;
  logic [31:0] patptr_r;
  logic [31:0] dstptr_r;
  logic [7:0] fill_r;
  logic [7:0] sign_r;
  logic flag_n_r, flag_z_r, flag_v_r, flag_c_r; // condition flags, c is significance
  logic busy_r, done_r, abort_r, badop_r;
  logic [7:0] op_r; // current operator
  logic [7:0] cnt_r; // remaining repeats of the operator
  logic [7:0] wch_r; // character waiting to be stored
  logic [3:0] dig_r; // last digit read
  logic wpend_r; // second store owed (float: sign then digit)
  logic mem_busy; // a memory request is out and not yet acknowledged

  // apb: zero-wait-state answer, writes only when idle
  wire acc = apb_req.psel & apb_req.penable;
  wire wr = acc & apb_req.pwrite;
  wire known = apb_req.paddr inside {DEP_CTRL, DEP_STAT, DEP_SRCLEN, DEP_SRCPTR, DEP_SIGNFILL,
                                     DEP_PATPTR, DEP_DSTPTR};
  assign pready = 1'b1;
  assign pslverr = acc & ~known;
  assign done = done_r;

  // read data register, zero for unmapped
  // loaded in the setup cycle, so the access phase still needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_req.psel && !apb_req.penable) begin
      case (apb_req.paddr)
        DEP_STAT: prdata <= {24'h0, flag_c_r, flag_v_r, flag_z_r, flag_n_r, badop_r, abort_r, done_r, busy_r};
        DEP_SRCLEN: prdata <= srclen_r;
        DEP_SRCPTR: prdata <= srcptr_r;
        DEP_SIGNFILL: prdata <= {16'h0, sign_r, fill_r};
        DEP_PATPTR: prdata <= patptr_r;
        DEP_DSTPTR: prdata <= dstptr_r;
        default: prdata <= 32'h0;
      endcase
    end
  end

  // is the operator a digit mover (move or float)
  function automatic logic is_digit_op(input logic [7:0] op);
    is_digit_op = (op[7:4] == DEP_GRP_MOVE) || (op[7:4] == DEP_GRP_FLOAT);
  endfunction

  // digits still readable: remaining nibbles plus supplied zeros
  function automatic logic [16:0] digits_left(input logic [31:0] sl);
    // the upper half only counts while it is negative
    digits_left = {1'b0, sl[15:0]} + ({1'b0, 16'(~sl[31:16] + 16'h1)} & {17{sl[31]}});
  endfunction

  // memory: one access at a time, held until ack
  assign mem_busy = mem_req.req & ~mem_ack;
  wire start = wr && apb_req.paddr == DEP_CTRL && apb_req.pwdata[DEP_CTRL_GO] && !busy_r;
  // an odd count left points at a high nibble, an even one at a low nibble
  // so an even-length field starts one nibble into its first byte
  wire [7:0] nib = srclen_r[0] ? {4'h0, mem_rdata[7:4]} : {4'h0, mem_rdata[3:0]};

  // main sequencer; one operator finishes before the next fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= DEP_IDLE;
      // pointers and counts
      srclen_r <= 32'h0;
      srcptr_r <= 32'h0;
      patptr_r <= 32'h0;
      dstptr_r <= 32'h0;
      // fill and sign start as blanks
      fill_r <= DEP_FILL_RST;
      sign_r <= DEP_SIGN_RST;
      {flag_n_r, flag_z_r, flag_v_r, flag_c_r} <= 4'h0;
      {busy_r, done_r, abort_r, badop_r} <= 4'h0;
      // operator scratch
      op_r <= 8'h0;
      cnt_r <= 8'h0;
      wch_r <= 8'h0;
      dig_r <= 4'h0;
      wpend_r <= 1'b0;
      mem_req <= '0;
    end else begin
      // software writes while idle
      if (wr && !busy_r) begin
        case (apb_req.paddr)
          DEP_SRCLEN: srclen_r <= apb_req.pwdata;
          DEP_SRCPTR: srcptr_r <= apb_req.pwdata;
          DEP_SIGNFILL: {sign_r, fill_r} <= apb_req.pwdata[15:0];
          DEP_PATPTR: patptr_r <= apb_req.pwdata;
          DEP_DSTPTR: dstptr_r <= apb_req.pwdata;
          default: ;
        endcase
      end
      if (mem_ack) mem_req.req <= 1'b0;
      case (state_r)
        DEP_IDLE: begin
          if (start) begin
            // a new edit starts as a positive or negative zero, nothing significant yet
            busy_r <= 1'b1;
            done_r <= 1'b0;
            abort_r <= 1'b0;
            badop_r <= 1'b0;
            flag_n_r <= apb_req.pwdata[DEP_CTRL_NEG];
            flag_z_r <= 1'b1;
            flag_v_r <= 1'b0;
            flag_c_r <= 1'b0;
            state_r <= DEP_FETCH;
          end
        end
        DEP_FETCH: begin
          // read one pattern byte
          if (!mem_req.req) begin
            mem_req <= '{req: 1'b1, we: 1'b0, addr: patptr_r, wdata: 8'h0};
          end else if (mem_ack) begin
            op_r <= mem_rdata;
            patptr_r <= patptr_r + 32'h1;
            cnt_r <= {4'h0, mem_rdata[3:0]};
            state_r <= DEP_DECODE;
          end
        end
        DEP_DECODE: begin
          state_r <= DEP_FETCH;
          if (op_r == DEP_OP_END) begin
            if (digits_left(srclen_r) != 17'h0) abort_r <= 1'b1;
            if (flag_z_r) flag_n_r <= 1'b0;
            state_r <= DEP_FINISH;
          end else if (op_r == DEP_OP_ENDFLT) begin
            // the sign has not floated in yet, so it goes out now
            if (!flag_c_r) begin
              wch_r <= sign_r;
              flag_c_r <= 1'b1;
              state_r <= DEP_STORE;
            end
          end else if (op_r == DEP_OP_CLRSIG) begin
            flag_c_r <= 1'b0;
          end else if (op_r == DEP_OP_SETSIG) begin
            flag_c_r <= 1'b1;
          end else if (op_r == DEP_OP_STSIGN) begin
            wch_r <= sign_r;
            state_r <= DEP_STORE;
          end else if (op_r >= DEP_OP_LDFILL && op_r <= DEP_OP_ADJUST) begin
            // the 4x group carries one operand byte
            state_r <= DEP_OPND;
          end else if (op_r[7:4] == DEP_GRP_FILL && cnt_r != 8'h0) begin
            wch_r <= fill_r;
            state_r <= DEP_STORE;
          end else if (is_digit_op(op_r) && cnt_r != 8'h0) begin
            // refused before any digit moves, so no half-edited field is left
            if ({9'h0, cnt_r} > digits_left(srclen_r)) begin
              abort_r <= 1'b1;
              state_r <= DEP_FINISH;
            end else begin
              state_r <= DEP_DIGIT;
            end
          end else begin
            // reserved code: stop rather than guess
            badop_r <= 1'b1;
            state_r <= DEP_FINISH;
          end
        end
        DEP_OPND: begin
          // operand byte of the 4x group
          if (!mem_req.req) begin
            mem_req <= '{req: 1'b1, we: 1'b0, addr: patptr_r, wdata: 8'h0};
          end else if (mem_ack) begin
            patptr_r <= patptr_r + 32'h1;
            state_r <= DEP_FETCH;
            case (op_r)
              DEP_OP_LDFILL: fill_r <= mem_rdata;
              DEP_OP_LDSIGN: sign_r <= mem_rdata;
              DEP_OP_LDPLUS: if (!flag_n_r) sign_r <= mem_rdata;
              DEP_OP_LDMINUS: if (flag_n_r) sign_r <= mem_rdata;
              DEP_OP_INSERT: begin
                wch_r <= flag_c_r ? mem_rdata : fill_r;
                state_r <= DEP_STORE;
              end
              DEP_OP_BLANK: if (flag_z_r && mem_rdata != 8'h0) begin
                // back up, then reuse the fill loop for the stores
                dstptr_r <= dstptr_r - {24'h0, mem_rdata};
                cnt_r <= mem_rdata;
                wch_r <= fill_r;
                op_r <= {DEP_GRP_FILL, 4'h0};
                state_r <= DEP_STORE;
              end
              DEP_OP_REPSIGN: if (flag_z_r && mem_rdata != 8'h0) begin
                // the side write waits a cycle: no request may start on an acknowledging edge
                cnt_r <= mem_rdata;
                state_r <= DEP_FINISH;
              end
              default: begin // adjust input
                if (srclen_r[15:0] > {8'h0, mem_rdata}) begin
                  srclen_r[31:16] <= 16'h0;
                  cnt_r <= 8'(srclen_r[15:0] - {8'h0, mem_rdata});
                  state_r <= DEP_DROP;
                end else begin
                  srclen_r[31:16] <= srclen_r[15:0] - {8'h0, mem_rdata};
                end
              end
            endcase
          end
        end
        DEP_DIGIT, DEP_DROP: begin
          // one digit, supplied zeros first
          if (srclen_r[31]) begin
            srclen_r[31:16] <= srclen_r[31:16] + 16'h1;
            dig_r <= 4'h0;
            // a supplied zero is never significant by itself
            if (state_r == DEP_DIGIT) begin
              wch_r <= flag_c_r ? DEP_ASCII_ZERO : fill_r;
              state_r <= DEP_STORE;
            end
          end else if (!mem_req.req) begin
            mem_req <= '{req: 1'b1, we: 1'b0, addr: srcptr_r, wdata: 8'h0};
          end else if (mem_ack) begin
            srclen_r[15:0] <= srclen_r[15:0] - 16'h1;
            // the pointer moves on once the low nibble of a byte has been taken
            if (!srclen_r[0]) begin
              srcptr_r <= srcptr_r + 32'h1;
            end
            dig_r <= nib[3:0];
            if (state_r == DEP_DROP) begin
              // a lost nonzero digit is an overflow
              if (nib != 8'h0) begin
                flag_v_r <= 1'b1;
                flag_c_r <= 1'b1;
                flag_z_r <= 1'b0;
              end
              cnt_r <= cnt_r - 8'h1;
              if (cnt_r == 8'h1) begin
                state_r <= DEP_FETCH;
              end
            end else begin
              state_r <= DEP_STORE;
              if (nib != 8'h0) begin
                flag_z_r <= 1'b0;
                flag_c_r <= 1'b1;
                // first significant digit of a float: sign now, digit owed
                if (!flag_c_r && op_r[7:4] == DEP_GRP_FLOAT) begin
                  wch_r <= sign_r;
                  wpend_r <= 1'b1;
                end else begin
                  wch_r <= DEP_ASCII_ZERO + nib;
                end
              end else begin
                wch_r <= flag_c_r ? DEP_ASCII_ZERO : fill_r;
              end
            end
          end
        end
        DEP_STORE: begin
          // write wch_r at the destination pointer
          if (!mem_req.req) begin
            mem_req <= '{req: 1'b1, we: 1'b1, addr: dstptr_r, wdata: wch_r};
          end else if (mem_ack) begin
            dstptr_r <= dstptr_r + 32'h1;
            if (wpend_r) begin
              // the floated sign is out, the digit follows
              wpend_r <= 1'b0;
              wch_r <= DEP_ASCII_ZERO + {4'h0, dig_r};
            end else if (op_r[7:4] == DEP_GRP_FILL && cnt_r > 8'h1) begin
              cnt_r <= cnt_r - 8'h1;
            end else if (is_digit_op(op_r) && cnt_r > 8'h1) begin
              cnt_r <= cnt_r - 8'h1;
              state_r <= DEP_DIGIT;
            end else begin
              state_r <= DEP_FETCH;
            end
          end
        end
        DEP_FINISH: begin
          if (op_r == DEP_OP_REPSIGN) begin
            // side write of replace-sign, then back to the pattern
            if (!mem_req.req) begin
              mem_req <= '{req: 1'b1, we: 1'b1, addr: dstptr_r - {24'h0, cnt_r}, wdata: fill_r};
            end else if (mem_ack) begin
              state_r <= DEP_FETCH;
            end
          end else if (!mem_busy) begin
            // end, abort or bad operator: report and go idle
            busy_r <= 1'b0;
            done_r <= 1'b1;
            state_r <= DEP_IDLE;
          end
        end
        default: state_r <= DEP_IDLE;
      endcase
    end
  end
endmodule

// file: dv/dep_mem_model.sv
// byte memory model on the far side of the engine's memory port
`timescale 1ns/1ps
module dep_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // engine side
  input wire dep_pkg::dep_mem_req_t mem_req,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // wait cycles before each answer
  input wire logic [1:0] dly
);
  import dep_pkg::*;
  logic [7:0] mem [0:255]; // source, pattern and destination bytes
  logic [7:0] rd_r; // byte of the last read
  logic [1:0] cnt_r; // cycles waited on this request
  // one access at a time; never answers in the cycle right after an ack
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      cnt_r <= 2'h0;
      rd_r <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req.req && !mem_ack) begin
        if (cnt_r >= dly) begin
          mem_ack <= 1'b1;
          cnt_r <= 2'h0;
          if (mem_req.we) mem[mem_req.addr[7:0]] <= mem_req.wdata;
          else rd_r <= mem[mem_req.addr[7:0]];
        end else cnt_r <= cnt_r + 2'h1;
      end
    end
  end
  // outside the ack the bus shows the inverse, so a stale byte cannot pass
  assign mem_rdata = mem_ack ? rd_r : ~rd_r;
endmodule

// file: dv/dep_engine_asserts.sv
// concurrent checks on the pattern engine's ports
`timescale 1ns/1ps
module dep_engine_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire dep_pkg::dep_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // memory port and completion
  input wire dep_pkg::dep_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  input wire logic done
);
  import dep_pkg::*;
  logic acc; // access phase
  logic unm; // address outside the map
  logic go; // start command taken
  assign acc = apb_req.psel && apb_req.penable;
  assign unm = apb_req.paddr > DEP_DSTPTR || apb_req.paddr[1:0] != 2'h0;
  assign go = acc && apb_req.pwrite && apb_req.paddr == DEP_CTRL && apb_req.pwdata[DEP_CTRL_GO];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_ready: assert property (acc |-> pready) else $error("apb access not answered");
  chk_unmapped_err: assert property (acc && unm |-> pslverr) else $error("unmapped access without error");
  chk_mapped_ok: assert property (acc && !unm |-> !pslverr) else $error("mapped access flagged");
  chk_unmapped_zero: assert property (acc && unm && !apb_req.pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_req_held: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req))
    else $error("memory request changed before ack");
  chk_req_gap: assert property (mem_ack |=> !mem_req.req)
    else $error("memory request not released after ack");
  chk_done_quiet: assert property (done |-> !mem_req.req)
    else $error("memory access after completion");
  chk_done_holds: assert property (done && !go |=> done)
    else $error("completion dropped without start");
  chk_go_clears: assert property (go |-> ##[1:2] !done) else $error("start did not clear completion");
  // main scenarios
  cover property (go);
  cover property (mem_req.req && mem_req.we && mem_ack);
  cover property (acc && unm);
  cover property ($rose(done));
endmodule
bind dep_engine dep_engine_asserts dep_engine_asserts_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .done(done));

// file: dv/dep_engine_tb.sv
// self-checking bench for the decimal edit pattern engine
`timescale 1ns/1ps
module dep_engine_tb;
  import dep_pkg::*;
  logic pclk = 1'b0; // 25 MHz bus clock
  logic presetn = 1'b0; // active-low reset
  dep_apb_req_t req = '0; // bus request from the bench
  dep_mem_req_t mem_req;
  logic [31:0] prdata, rq;
  logic pready, pslverr, mem_ack, done, re;
  logic [7:0] mem_rdata;
  logic [1:0] dly = 2'h0; // memory delay, changed every run
  int fails = 0;
  int cmp_count = 0;
  always #20 pclk = ~pclk;
  dep_engine dep_engine_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done));
  dep_mem_model dep_mem_model_i (.clk(pclk), .rstn(presetn), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .dly(dly));
  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk) req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata;
    re = pslverr;
    req <= '0;
  endtask
  // load strings, start, wait for completion, judge flags and output
  task automatic run(input logic neg, input logic [15:0] src, input logic [15:0] nd, input logic [95:0] pat,
    input int plen, input string exp, input logic [7:0] msk, input logic [7:0] est);
    for (int i = 0; i < 32; i++) dep_mem_model_i.mem[128 + i] = 8'hee;
    dep_mem_model_i.mem[0] = src[15:8];
    dep_mem_model_i.mem[1] = src[7:0];
    dep_mem_model_i.mem[2] = 8'h0c; // sign nibble low; an even count's last digit sits in its high nibble
    for (int i = 0; i < plen; i++) dep_mem_model_i.mem[64 + i] = pat[8 * (plen - 1 - i) +: 8];
    dly <= dly + 2'h1;
    apb(1'b1, DEP_SIGNFILL, 32'h2020);
    apb(1'b1, DEP_SRCLEN, {16'h0, nd});
    apb(1'b1, DEP_SRCPTR, 32'h0);
    apb(1'b1, DEP_PATPTR, 32'h40);
    apb(1'b1, DEP_DSTPTR, 32'h80);
    apb(1'b1, DEP_CTRL, {30'h0, neg, 1'b1});
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 4000 && done !== 1'b1; k++) @(posedge pclk);
    check("run done", {31'h0, done}, 32'h1);
    apb(1'b0, DEP_STAT, 32'h0);
    check("status", rq & {24'h0, msk}, {24'h0, est});
    for (int i = 0; i < exp.len(); i++) check("dest byte", {24'h0, dep_mem_model_i.mem[128 + i]}, {24'h0, exp[i]});
    if (msk == 8'hff) begin
      apb(1'b0, DEP_DSTPTR, 32'h0);
      check("dest ptr", rq, 32'h80 + exp.len());
      check("byte past end", {24'h0, dep_mem_model_i.mem[128 + exp.len()]}, 32'hee);
    end
  endtask
  // reset value of sign and fill, an unmapped read
  task automatic t_regs();
    apb(1'b0, DEP_SIGNFILL, 32'h0);
    check("sign fill reset", rq, 32'h2020);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", {31'h0, re}, 32'h1);
    check("unmapped data", rq, 32'h0);
  endtask
  // leading zero suppression with check protection and inserts
  task automatic t_move();
    run(1'b0, 16'h0012, 16'h4, 96'h402a92442c9200, 7, "*1,20", 8'hff, 8'h82);
    run(1'b0, 16'h0050, 16'h3, 96'h03029300, 4, "  5", 8'hff, 8'h82);
    run(1'b0, 16'h0, 16'h0, 96'h40238f00, 4, "###############", 8'hff, 8'h22);
  endtask
  // floating sign sequences and conditional sign loads
  task automatic t_float();
    run(1'b1, 16'h0050, 16'h3, 96'h412da30100, 5, "  -5", 8'hff, 8'h92);
    run(1'b0, 16'h0, 16'h2, 96'h422b4344a20100, 7, "  +", 8'hff, 8'ha2);
    run(1'b1, 16'h1000, 16'h1, 96'h422b432d049100, 7, "-1", 8'hff, 8'h92);
  endtask
  // surplus digits dropped, missing digits supplied as zeros
  task automatic t_adjust();
    run(1'b0, 16'h1230, 16'h3, 96'h47019100, 4, "3", 8'hff, 8'hc2);
    run(1'b0, 16'h7000, 16'h1, 96'h47039300, 4, "  7", 8'hff, 8'h82);
  endtask
  // backward fixups on a negative zero
  task automatic t_blank();
    run(1'b1, 16'h0, 16'h2, 96'h412d040392450300, 8, "   ", 8'hff, 8'ha2);
    run(1'b1, 16'h0, 16'h1, 96'h402a412d040391460200, 10, "*0", 8'hff, 8'ha2);
  endtask
  // end with digits left, counts beyond the source, and a reserved operator
  task automatic t_abort();
    run(1'b0, 16'h7000, 16'h1, 96'h470300, 3, "", 8'h0f, 8'h06);
    apb(1'b0, DEP_SRCLEN, 32'h0);
    check("zeros to supply", rq, 32'hfffe0001);
    run(1'b0, 16'h1000, 16'h1, 96'h9200, 2, "", 8'h0f, 8'h06);
    run(1'b0, 16'h1000, 16'h1, 96'ha200, 2, "", 8'h0f, 8'h06);
    run(1'b0, 16'h0, 16'h0, 96'h0500, 2, "", 8'h0f, 8'h0a);
  endtask
  // verdict and end of run
  task automatic summarize();
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_move();
    t_float();
    t_adjust();
    t_blank();
    t_abort();
    summarize();
  end
  // watchdog, far beyond the thousand or so cycles the runs need
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    summarize();
  end
endmodule
